// File: rtl/sspin_pkg.sv
// Constants for the strap sampling and status pin block
package sspin_pkg;
   localparam int unsigned SSPIN_PORTS = 4;
   // Divider charging mode set
   localparam logic [1:0] SSPIN_DIV_ALL  = 2'h0;
   localparam logic [1:0] SSPIN_DIV_TOP  = 2'h1;
   localparam logic [1:0] SSPIN_DIV_NONE = 2'h2;
   // APB map
   localparam logic [11:0] SSPIN_CTRL_OFS   = 12'h000;
   localparam logic [11:0] SSPIN_STRAP_OFS  = 12'h004;
   localparam logic [11:0] SSPIN_PORT_OFS   = 12'h008;
   localparam logic [11:0] SSPIN_STATUS_OFS = 12'h00c;
   // Control fields
   localparam int unsigned SSPIN_CTRL_STSEN = 0;
   localparam int unsigned SSPIN_CTRL_TOPC  = 1;
   // Strap readback fields
   localparam int unsigned SSPIN_ST_PMGMT = 0;
   localparam int unsigned SSPIN_ST_POL   = 1;
   localparam int unsigned SSPIN_ST_IFACE = 2;
   localparam int unsigned SSPIN_ST_AUTO  = 3;
   localparam int unsigned SSPIN_ST_DONE  = 4;
   localparam logic [31:0] SSPIN_CTRL_RST = 32'h0000_0000;
   localparam logic [3:0]  SSPIN_PORT_RST = 4'h0;
   typedef enum logic [1:0] {
      SSPIN_RESET  = 2'b00,
      SSPIN_SAMPLE = 2'b01,
      SSPIN_RUN    = 2'b10,
      SSPIN_FILL   = 2'b11
   } sspin_state_t;
endpackage

// File: rtl/sspin_top.sv
// Strap sampling, power output polarity and status pin driving
`timescale 1ns/100ps
module sspin_top
   import sspin_pkg::*;
#(
   parameter int unsigned PORTS = SSPIN_PORTS
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             pmgmt_pin_in,
   output logic                  pmgmt_pin_out,
   output logic                  pmgmt_pin_oe,
   input  wire logic             iface_pin_in,
   output logic                  iface_pin_out,
   output logic                  iface_pin_oe,
   input  wire logic             power_out_polarity_strap,
   input  wire logic             auto_charge_strap_n,
   input  wire logic             ss_connected,
   input  wire logic             ss_suspended,
   output logic      [PORTS-1:0] port_power_out,
   output logic                  slave_addr_bit1,
   output logic                  i2c_master_sel,
   output logic                  auto_charge_en,
   output logic                  power_mgmt_strap_n,
   output logic      [1:0]       divider_charge_mode
);

   // Pin synchronisers, two flops each
   logic [3:0] sync1_r, sync2_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= {auto_charge_strap_n, power_out_polarity_strap, iface_pin_in, pmgmt_pin_in};
         sync2_r <= sync1_r;
      end
   end

   // Status inputs come from the same clock domain
   sspin_state_t state_r, state_nxt;
   logic pmgmt_r, pmgmt_nxt, pol_r, pol_nxt, iface_r, iface_nxt, auto_r, auto_nxt;
   logic stsen_r, stsen_nxt, topc_r, topc_nxt;
   logic [PORTS-1:0] port_en_r, port_en_nxt;
   logic [PORTS-1:0] pwr_r, pwr_nxt;
   logic suspo_r, suspo_nxt, conno_r, conno_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic wr_en, rd_en, mapped;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign mapped = (paddr == SSPIN_CTRL_OFS) || (paddr == SSPIN_STRAP_OFS) ||
                   (paddr == SSPIN_PORT_OFS) || (paddr == SSPIN_STATUS_OFS);

   always_comb begin
      state_nxt   = state_r;
      pmgmt_nxt   = pmgmt_r;
      pol_nxt     = pol_r;
      iface_nxt   = iface_r;
      auto_nxt    = auto_r;
      stsen_nxt   = stsen_r;
      topc_nxt    = topc_r;
      port_en_nxt = port_en_r;
      unique case (state_r)
         // Synchroniser needs two edges to fill before the pins are trusted
         SSPIN_RESET: begin
            state_nxt = SSPIN_FILL;
         end
         // Extra cycle so the second flop holds a pin level taken after release
         SSPIN_FILL: begin
            state_nxt = SSPIN_SAMPLE;
         end
         SSPIN_SAMPLE: begin
            state_nxt = SSPIN_RUN;
            pmgmt_nxt = sync2_r[0];
            pol_nxt   = sync2_r[2];
            iface_nxt = sync2_r[1];
            auto_nxt  = sync2_r[3];
            topc_nxt  = sync2_r[0];
         end
         SSPIN_RUN: begin
            if (wr_en && paddr == SSPIN_CTRL_OFS) begin
               stsen_nxt = pwdata[SSPIN_CTRL_STSEN];
               topc_nxt  = pwdata[SSPIN_CTRL_TOPC];
            end
            if (wr_en && paddr == SSPIN_PORT_OFS) begin
               port_en_nxt = pwdata[PORTS-1:0];
            end
         end
      endcase
   end

   always_comb begin
      for (int i = 0; i < PORTS; i++) begin
         pwr_nxt[i] = ((state_r == SSPIN_RUN) && !pmgmt_r && port_en_r[i]) ? pol_r : !pol_r;
      end
      if (state_r != SSPIN_RUN) begin
         pwr_nxt = '0;
      end
      suspo_nxt = ss_suspended;
      conno_nxt = ss_connected;
      prdata_nxt = prdata_r;
      if (rd_en) begin
         unique case (paddr)
            SSPIN_CTRL_OFS:   prdata_nxt = {30'h0, topc_r, stsen_r};
            SSPIN_STRAP_OFS:  prdata_nxt = {27'h0, state_r == SSPIN_RUN, auto_r, iface_r, pol_r, pmgmt_r};
            SSPIN_PORT_OFS:   prdata_nxt = {{(32-PORTS){1'b0}}, port_en_r};
            SSPIN_STATUS_OFS: prdata_nxt = {30'h0, ss_connected, ss_suspended};
            default:          prdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r   <= SSPIN_RESET;
         pmgmt_r   <= 1'b1;
         pol_r     <= 1'b1;
         iface_r   <= 1'b1;
         auto_r    <= 1'b1;
         stsen_r   <= SSPIN_CTRL_RST[SSPIN_CTRL_STSEN];
         topc_r    <= SSPIN_CTRL_RST[SSPIN_CTRL_TOPC];
         port_en_r <= SSPIN_PORT_RST;
         pwr_r     <= '0;
         suspo_r   <= 1'b0;
         conno_r   <= 1'b0;
         prdata_r  <= 32'h0;
      end else begin
         state_r   <= state_nxt;
         pmgmt_r   <= pmgmt_nxt;
         pol_r     <= pol_nxt;
         iface_r   <= iface_nxt;
         auto_r    <= auto_nxt;
         stsen_r   <= stsen_nxt;
         topc_r    <= topc_nxt;
         port_en_r <= port_en_nxt;
         pwr_r     <= pwr_nxt;
         suspo_r   <= suspo_nxt;
         conno_r   <= conno_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   // pins drive only after sampling and when enabled
   assign pmgmt_pin_oe  = (state_r == SSPIN_RUN) && stsen_r;
   assign iface_pin_oe  = (state_r == SSPIN_RUN) && stsen_r;
   assign pmgmt_pin_out = conno_r;
   assign iface_pin_out = suspo_r;

   assign port_power_out     = pwr_r;
   assign power_mgmt_strap_n = pmgmt_r;
   assign slave_addr_bit1    = pmgmt_r && !iface_r;
   assign i2c_master_sel     = iface_r;
   assign auto_charge_en     = (state_r == SSPIN_RUN) && !auto_r;
   assign divider_charge_mode = !auto_charge_en ? SSPIN_DIV_NONE : (topc_r ? SSPIN_DIV_TOP : SSPIN_DIV_ALL);

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   a_strap_latch: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_SAMPLE) |=> (pmgmt_r == $past(sync2_r[0])))
      else $error("power strap not latched");
   a_pol_latch: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_SAMPLE) |=> (pol_r == $past(sync2_r[2])))
      else $error("polarity strap not latched");
   a_topc_seed: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_SAMPLE) |=> (topc_r == $past(sync2_r[0])))
      else $error("top current bit not seeded");
   a_iface_latch: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_SAMPLE) |=> (iface_r == $past(sync2_r[1])))
      else $error("interface strap not latched");
   a_auto_mode: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && auto_r) |-> (divider_charge_mode == SSPIN_DIV_NONE))
      else $error("auto mode active despite strap");
   a_div_all: assert property (@(posedge clk) disable iff (!resetn)
      (auto_charge_en && !topc_r) |-> (divider_charge_mode == SSPIN_DIV_ALL))
      else $error("divider modes not all allowed");
   a_div_top: assert property (@(posedge clk) disable iff (!resetn)
      (auto_charge_en && topc_r) |-> (divider_charge_mode == SSPIN_DIV_TOP))
      else $error("top current mode not used");
   a_addr_bit: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && !iface_r) |-> (slave_addr_bit1 == pmgmt_r))
      else $error("slave address bit wrong");
   a_susp_pin: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && stsen_r) |=> (iface_pin_out == $past(ss_suspended)))
      else $error("suspend pin wrong");
   a_conn_pin: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && stsen_r) |=> (pmgmt_pin_out == $past(ss_connected)))
      else $error("connection pin wrong");
   a_pin_quiet: assert property (@(posedge clk) disable iff (!resetn)
      (state_r != SSPIN_RUN) |-> (!pmgmt_pin_oe && !iface_pin_oe))
      else $error("strap pin driven too early");
   a_pwr_on: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && !pmgmt_r && port_en_r[0]) |=> (port_power_out[0] == pol_r))
      else $error("port power not asserted");

   // Release order: one fill cycle for the synchroniser, one sampling cycle, then running
   sequence s_released;
      (state_r == SSPIN_RESET) ##1 (state_r == SSPIN_FILL);
   endsequence
   sequence s_latched;
      (state_r == SSPIN_SAMPLE) ##1 (state_r == SSPIN_RUN);
   endsequence
   a_release_order: assert property (@(posedge clk) disable iff (!resetn)
      s_released
      |=> s_latched)
      else $error("strap sampling order broken");
   a_auto_latch: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_SAMPLE)
      |=> (auto_r == $past(sync2_r[3])))
      else $error("auto charge strap not latched");
   a_straps_hold: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN)
      |=> ($stable(pmgmt_r) && $stable(pol_r) && $stable(iface_r) && $stable(auto_r)))
      else $error("latched strap changed while running");
   a_pwr_pre_run: assert property (@(posedge clk) disable iff (!resetn)
      (state_r != SSPIN_RUN)
      |-> (port_power_out == '0))
      else $error("port power driven before straps known");
   a_pwr_unsup: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && pmgmt_r)
      |=> (port_power_out == {PORTS{!pol_r}}))
      else $error("port power switched without power management");
   a_addr_i2c: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && iface_r)
      |-> !slave_addr_bit1)
      else $error("address bit set outside SMBus mode");
   a_addr_pre_run: assert property (@(posedge clk) disable iff (!resetn)
      (state_r != SSPIN_RUN)
      |-> !slave_addr_bit1)
      else $error("address bit set before straps known");
   a_oe_on: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && stsen_r)
      |-> (pmgmt_pin_oe && iface_pin_oe))
      else $error("status pins not driven when enabled");
   a_oe_off: assert property (@(posedge clk) disable iff (!resetn)
      (!stsen_r)
      |-> (!pmgmt_pin_oe && !iface_pin_oe))
      else $error("status pins driven while disabled");
   a_ctrl_write: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && wr_en && paddr == SSPIN_CTRL_OFS)
      |=> (stsen_r == $past(pwdata[SSPIN_CTRL_STSEN]) && topc_r == $past(pwdata[SSPIN_CTRL_TOPC])))
      else $error("control write not taken");
   a_topc_steady: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && !(wr_en && paddr == SSPIN_CTRL_OFS))
      |=> $stable(topc_r))
      else $error("top current bit changed without a write");
   a_div_legal: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN)
      |-> (divider_charge_mode != 2'h3))
      else $error("illegal divider mode code");
   a_auto_on: assert property (@(posedge clk) disable iff (!resetn)
      (state_r == SSPIN_RUN && !auto_r)
      |-> auto_charge_en)
      else $error("auto charge not enabled by strap");
   a_auto_pre: assert property (@(posedge clk) disable iff (!resetn)
      (state_r != SSPIN_RUN)
      |-> (!auto_charge_en && divider_charge_mode == SSPIN_DIV_NONE))
      else $error("auto charge active before straps known");
   a_status_rd: assert property (@(posedge clk) disable iff (!resetn)
      (rd_en && paddr == SSPIN_STATUS_OFS)
      |=> (prdata == {30'h0, $past(ss_connected), $past(ss_suspended)}))
      else $error("status readback wrong");
   a_strap_rd: assert property (@(posedge clk) disable iff (!resetn)
      (rd_en && paddr == SSPIN_STRAP_OFS)
      |=> (prdata[SSPIN_ST_PMGMT] == $past(pmgmt_r) && prdata[SSPIN_ST_POL] == $past(pol_r)))
      else $error("strap readback wrong");
   a_port_rd: assert property (@(posedge clk) disable iff (!resetn)
      (rd_en && paddr == SSPIN_PORT_OFS)
      |=> (prdata[PORTS-1:0] == $past(port_en_r)))
      else $error("port enable readback wrong");

   for (genvar g = 0; g < PORTS; g++) begin : g_port_chk
      a_port_on: assert property (@(posedge clk) disable iff (!resetn)
         (state_r == SSPIN_RUN && !pmgmt_r && port_en_r[g])
         |=> (port_power_out[g] == pol_r))
         else $error("port power not driven active");
      a_port_off: assert property (@(posedge clk) disable iff (!resetn)
         (state_r == SSPIN_RUN && !port_en_r[g])
         |=> (port_power_out[g] == !pol_r))
         else $error("idle port not at inactive level");
   end

endmodule

// File: tb/sspin_board.sv
// Board model: strap resistors on the two shared pins
`timescale 1ns/100ps
module sspin_board (
   input  wire logic pmgmt_strap,
   input  wire logic iface_strap,
   input  wire logic pmgmt_pin_out,
   input  wire logic pmgmt_pin_oe,
   input  wire logic iface_pin_out,
   input  wire logic iface_pin_oe,
   output logic      pmgmt_pin,
   output logic      iface_pin
);
   // board straps power mgmt and interface
   // Strap resistor only wins while the device leaves the pin alone
   assign pmgmt_pin = pmgmt_pin_oe ? pmgmt_pin_out : pmgmt_strap;
   assign iface_pin = iface_pin_oe ? iface_pin_out : iface_strap;
endmodule

// File: tb/strap_sampling_status_pins_tb.sv
// Self-checking bench for strap sampling and status pins
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module strap_sampling_status_pins_tb;
   import sspin_pkg::*;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, pm_s = 1, if_s = 1, pol_s = 1, au_s = 1, conn = 0, susp = 0;
   logic pm_pin, pm_out, pm_oe, if_pin, if_out, if_oe, addr1, i2c, aut, pmn;
   logic [3:0] pwr;
   logic [1:0] dmode;
   int n_fail = 0, check_count = 0;
   initial forever #2 clk = ~clk;
   sspin_board board_u (.pmgmt_strap(pm_s), .iface_strap(if_s), .pmgmt_pin_out(pm_out), .pmgmt_pin_oe(pm_oe),
      .iface_pin_out(if_out), .iface_pin_oe(if_oe), .pmgmt_pin(pm_pin), .iface_pin(if_pin));
   sspin_top dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pmgmt_pin_in(pm_pin),
      .pmgmt_pin_out(pm_out), .pmgmt_pin_oe(pm_oe), .iface_pin_in(if_pin), .iface_pin_out(if_out),
      .iface_pin_oe(if_oe), .power_out_polarity_strap(pol_s), .auto_charge_strap_n(au_s), .ss_connected(conn),
      .ss_suspended(susp), .port_power_out(pwr), .slave_addr_bit1(addr1), .i2c_master_sel(i2c),
      .auto_charge_en(aut), .power_mgmt_strap_n(pmn), .divider_charge_mode(dmode));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      // Wait for the slave, never assuming its latency
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic strap_reset(input logic pm, ifc, pol, au);
      resetn <= 0; pm_s <= pm; if_s <= ifc; pol_s <= pol; au_s <= au;
      repeat (10) @(posedge clk);
      `CHK("pins_oe_rst", 2'b00, {pm_oe, if_oe})
      `CHK("pwr_rst", 4'h0, pwr)
      `CHK("div_rst", SSPIN_DIV_NONE, dmode)
      resetn <= 1;
      repeat (6) @(posedge clk);
   endtask
   task automatic scen_enabled_straps;
      strap_reset(0, 1, 1, 0);
      `CHK("pmgmt_n", 1'b0, pmn)
      `CHK("i2c_sel", 1'b1, i2c)
      `CHK("addr1", 1'b0, addr1)
      `CHK("auto_en", 1'b1, aut)
      `CHK("div_all", SSPIN_DIV_ALL, dmode)
      apb(0, SSPIN_STRAP_OFS, 0);
      `CHK("strap_rd", 32'h0000_0016, rd)
      apb(0, SSPIN_CTRL_OFS, 0);
      `CHK("ctrl_rd", 32'h0000_0000, rd)
      apb(1, SSPIN_CTRL_OFS, 32'h0000_0002);
      @(posedge clk);
      `CHK("div_top", SSPIN_DIV_TOP, dmode)
      apb(1, SSPIN_PORT_OFS, 32'h0000_0005);
      repeat (2) @(posedge clk);
      `CHK("pwr_hi", 4'h5, pwr)
      `CHK("pins_oe_off", 2'b00, {pm_oe, if_oe})
      conn <= 1; susp <= 0;
      apb(1, SSPIN_CTRL_OFS, 32'h0000_0001);
      repeat (3) @(posedge clk);
      `CHK("pins_oe_on", 2'b11, {pm_oe, if_oe})
      `CHK("conn_pin", 1'b1, pm_pin)
      `CHK("susp_pin", 1'b0, if_pin)
      apb(0, SSPIN_STATUS_OFS, 0);
      `CHK("status_rd", 32'h0000_0002, rd)
      conn <= 0; susp <= 1;
      repeat (3) @(posedge clk);
      `CHK("conn_pin0", 1'b0, pm_pin)
      `CHK("susp_pin1", 1'b1, if_pin)
      apb(0, 12'h010, 0);
      `CHK("unmapped", 33'h1_0000_0000, {err, rd})
   endtask
   task automatic scen_disabled_straps;
      strap_reset(1, 0, 0, 1);
      `CHK("pmgmt_n1", 1'b1, pmn)
      `CHK("i2c_sel0", 1'b0, i2c)
      `CHK("addr1_hi", 1'b1, addr1)
      `CHK("auto_off", 1'b0, aut)
      `CHK("div_none", SSPIN_DIV_NONE, dmode)
      apb(0, SSPIN_STRAP_OFS, 0);
      `CHK("strap_rd2", 32'h0000_0019, rd)
      apb(0, SSPIN_CTRL_OFS, 0);
      `CHK("ctrl_seed", 32'h0000_0002, rd)
      // Power switching unsupported, so outputs stay at inactive level
      apb(1, SSPIN_PORT_OFS, 32'h0000_0003);
      repeat (2) @(posedge clk);
      `CHK("pwr_lo_off", 4'hf, pwr)
   endtask
   task automatic scen_active_low;
      strap_reset(0, 0, 0, 1);
      `CHK("addr1_smb0", 1'b0, addr1)
      `CHK("i2c_sel_smb", 1'b0, i2c)
      `CHK("auto_off2", 1'b0, aut)
      `CHK("pwr_idle_hi", 4'hf, pwr)
      apb(0, SSPIN_STRAP_OFS, 0);
      `CHK("strap_rd3", 32'h0000_0018, rd)
      apb(1, SSPIN_PORT_OFS, 32'h0000_0006);
      repeat (2) @(posedge clk);
      `CHK("pwr_act_lo", 4'h9, pwr)
      conn <= 1; susp <= 1;
      apb(1, SSPIN_CTRL_OFS, 32'h0000_0003);
      @(posedge clk);
      `CHK("div_none_top", SSPIN_DIV_NONE, dmode)
      repeat (2) @(posedge clk);
      `CHK("conn_pin1", 1'b1, pm_pin)
      `CHK("susp_pin_hi", 1'b1, if_pin)
   endtask
   task automatic wrap_up;
      if (n_fail == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      wrap_up;
   end
   initial begin
      scen_enabled_straps;
      scen_disabled_straps;
      scen_active_low;
      wrap_up;
   end
endmodule
